/* File: bench/slc_core_model.sv */
/*
 stand-in for the processor core: issues the one-cycle sleep opcode pulse.
 assumes the bench asks with go_i and the controller halts via cpu_halt_i.
*/
`timescale 1ns/1ps
`default_nettype none
module slc_core_model (
   input  wire logic clk_i,      // system clock
   input  wire logic rst_i,      // sync reset, active high
   input  wire logic go_i,       // program reached the opcode
   input  wire logic cpu_halt_i, // core clock stopped
   output logic      sleep_op_o  // one-cycle opcode pulse
);
   // a halted core executes nothing, so a request while halted is lost
   always_ff @(posedge clk_i) begin
      sleep_op_o <= !rst_i && go_i && !cpu_halt_i && !sleep_op_o;
   end
endmodule // slc_core_model
`default_nettype wire

/* File: bench/tb.sv */
/*
 self-checking bench for the sleep controller, first variant.
 assumes the package, the controller and the core stand-in compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   import slc_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0, q;
   slc_wake_t   wake = '0;
   wire  [31:0] rd;
   wire         op, halt, osc, srst, irqgo, pinen, cmpoff, ack;
   wire  [4:0]  obs = {halt, osc, srst, irqgo, pinen};
   int          bad_count = 0, num_checks = 0, n;
   int          mdl_ctrl = 0, mdl_cmp = 0;
   // depth bit, then wake vector; idle sources first, power-down after
   logic [6:0]  tbl [7] = '{7'h01, 7'h04, 7'h18, 7'h44, 7'h42, 7'h60, 7'h58};

   always #2 clk_i = ~clk_i;

   slc_sleep_ctrl #(.VARIANT_B(1'b0)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
      .sleep_op_i(op), .wake_i(wake), .cpu_halt_o(halt), .osc_stop_o(osc),
      .sys_reset_o(srst), .irq_go_o(irqgo), .pin_flag_en_o(pinen), .cmp_off_o(cmpoff));
   slc_core_model core (
      .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .cpu_halt_i(halt), .sleep_op_o(op));

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // classic single cycle; request held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (k >= 20) begin
         chk("bus ack", 1, 0);
         test_done();
      end
      q = rd;
      cyc <= 0;
      stb <= 0;
   endtask
   // bounded wait for one observed output to reach a level
   task automatic wait_for(input int i, input logic v);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (obs[i] !== v && n < 40);
      if (n >= 40) begin
         chk("wait level", 1, 0);
         test_done();
      end
   endtask
   task automatic pulse_go();
      @(posedge clk_i);
      go <= 1;
      @(posedge clk_i);
      go <= 0;
   endtask
   // arm just before the opcode, then confirm the chosen depth
   task automatic nap(input logic d);
      mdl_ctrl = (1 << SLC_ARM_BIT) | (d << SLC_DEPTH_BIT);
      bus(1, SLC_CTRL_OFS, mdl_ctrl);
      pulse_go();
      wait_for(4, 1);
      bus(0, SLC_STATUS_OFS, 0);
      chk("sleep state", d ? 2 : 1, q & 3);
      chk("osc stop", d, osc);
   endtask

   initial begin
      n = $urandom(32'h8b5712fc);
      repeat (4) @(posedge clk_i);
      rst_i <= 0;
      bus(0, SLC_CTRL_OFS, 0);
      chk("ctrl reset", SLC_CTRL_RST, q);
      bus(0, SLC_CMP_OFS, 0);
      chk("cmp reset", SLC_CMP_RST, q);
      bus(0, 8'h0c, 0);
      chk("unmapped read", 0, q);
      repeat (4) begin
         mdl_cmp = $urandom;
         bus(1, SLC_CMP_OFS, mdl_cmp);
         bus(0, SLC_CMP_OFS, 0);
         chk("cmp bit", mdl_cmp[7], q[7]);
         chk("cmp off", mdl_cmp[7], cmpoff);
      end
      // unarmed opcode with a random depth must change nothing
      mdl_ctrl = $urandom & 32'h10;
      bus(1, SLC_CTRL_OFS, mdl_ctrl);
      pulse_go();
      repeat (6) @(posedge clk_i);
      chk("unarmed opcode", 0, {osc, halt});
      foreach (tbl[i]) begin
         nap(tbl[i][6]);
         if (tbl[i][6]) begin
            wake <= 6'h11;
            repeat (6) @(posedge clk_i);
            chk("pdown ignores", 3, {osc, halt});
         end
         // wake level stays up until the block is awake again
         wake <= tbl[i][5:0];
         if (tbl[i][5] | tbl[i][4]) begin
            wait_for(2, 1);
            @(posedge clk_i);
            chk("reset pulse", 0, srst);
            chk("halt after reset", 0, halt);
         end else if (tbl[i] == 7'h42) begin
            wait_for(0, 0);
            wait_for(0, 1);
            chk("pin stall", 2, n);
         end else begin
            wait_for(4, 0);
            if (!tbl[i][6]) chk("idle resume", 3, n);
            wait_for(1, 1);
            bus(0, SLC_CTRL_OFS, 0);
            chk("ctrl kept", mdl_ctrl, q & 32'h30);
         end
         wake <= '0;
         repeat (2) @(posedge clk_i);
         chk("osc running", 0, osc);
      end
      test_done();
   end
endmodule // tb
`default_nettype wire

/* File: hw/slc_pkg.sv */
/*
 sleep controller package: register map, bit positions, reset values,
 stall counts and the wake-source carrier.
 assumes a 32-bit classic wishbone register bus, word addressed by byte.
*/
`default_nettype none
package slc_pkg;
   // register byte offsets
   localparam logic [7:0] SLC_CTRL_OFS   = 8'h00; // processor_control_register
   localparam logic [7:0] SLC_STATUS_OFS = 8'h04; // sleep state and stall count
   localparam logic [7:0] SLC_CMP_OFS    = 8'h08; // comparator_control_status_register
   // field positions
   localparam int SLC_ARM_BIT   = 5;  // low_power_arm_bit
   localparam int SLC_DEPTH_BIT = 4;  // low_power_depth_select
   localparam int SLC_CMP_OFF_BIT = 7; // comparator_power_off_bit
   // reset values
   localparam logic [7:0] SLC_CTRL_RST = 8'h00;
   localparam logic [7:0] SLC_CMP_RST  = 8'h00;
   // post-wake stall counts in cpu cycles
   localparam logic [2:0] SLC_PIN_WAKE_CYC = 3'h2; // variant a, pin-change wake
   localparam logic [2:0] SLC_IRQ_HALT_CYC = 3'h4; // variant b, irq wake
   localparam logic [2:0] SLC_IDLE_WAKE_CYC = 3'h0; // variant a, idle wake

   typedef enum logic [1:0] {
      SLC_RUN,
      SLC_IDLE,
      SLC_PDOWN,
      SLC_STALL
   } slc_state_t;

   // wake sources presented by the surrounding logic
   typedef struct packed {
      logic ext_reset;  // external reset request
      logic wdt_reset;  // watchdog expiry
      logic wdt_en;     // watchdog enabled
      logic level_irq;  // external_level_irq, enabled and asserted
      logic pin_irq;    // pin-change irq, enabled and asserted
      logic other_irq;  // any other enabled irq (timer, comparator)
   } slc_wake_t;
endpackage
`default_nettype wire

/* File: hw/slc_sleep_ctrl.sv */
/*
 sleep-mode controller: control register with arm and depth bits,
 idle / power-down sequencing, wake source filtering and post-wake stall.
 assumes the core pulses sleep_op_i for one cycle when it executes the
 sleep opcode, and that wake inputs are already filtered and synchronous.
 outputs are registered; the clock gates themselves sit outside,
 driven from cpu_halt_o and osc_stop_o.
*/
// The implementer's own choices: the register offsets and the Wishbone register port.
// Function
// [R1] software arms then executes the sleep opcode
// [R2] depth clear selects idle, cpu halted
// [R3] depth set selects power-down
// [R4] enabled irq wakes, resume after opcode
// [R5] variant a pin wake runs two cycles
// [R6] sleeping never touches register file state
// [R7] reset during sleep restarts at reset vector
// [R8] idle wakes on external and internal events
// [R9] software powers comparator off before idle
// [R10] variant a idle wake resumes immediately
// [R11] power-down stops the main oscillator
// [R12] only four sources end power-down
// [R13] wake level must outlast reset delay
// [R14] variant b irq wake halts four cycles
// [R15] arm bit 5, depth bit 4, reset zero
// [R16] software arms just before the opcode
// [R17] unarmed sleep opcode acts as no-op
`timescale 1ns/1ps
`default_nettype none
module slc_sleep_ctrl
   import slc_pkg::*;
#(
   parameter bit VARIANT_B = 1'b0         // 0: first variant, 1: second
) (
   input  wire logic        clk_i,        // 250 MHz system clock
   input  wire logic        rst_i,        // synchronous reset, active high
   input  wire logic        wb_cyc_i,     // wishbone cycle
   input  wire logic        wb_stb_i,     // wishbone strobe
   input  wire logic        wb_we_i,      // wishbone write enable
   input  wire logic [7:0]  wb_adr_i,     // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,     // wishbone byte selects
   input  wire logic [31:0] wb_dat_i,     // wishbone write data
   output logic      [31:0] wb_dat_o,     // wishbone read data
   output logic             wb_ack_o,     // wishbone acknowledge
   input  wire logic        sleep_op_i,   // core executes sleep opcode
   input  wire slc_wake_t   wake_i,       // wake sources
   output logic             cpu_halt_o,   // stop cpu clock
   output logic             osc_stop_o,   // stop main oscillator
   output logic             sys_reset_o,  // reset to vector pulse
   output logic             irq_go_o,     // let core take pending irq
   output logic             pin_flag_en_o,// pin-change flag may update
   output logic             cmp_off_o     // comparator power off
);

   slc_state_t  state_r;
   logic [7:0]  ctrl_r;
   logic [7:0]  cmp_r;
   logic [2:0]  stall_r;
   logic        stall_pin_r;     // current stall follows a pin wake
   logic        cpu_halt_r;
   logic        osc_stop_r;
   logic        sys_reset_r;
   logic        irq_go_r;
   logic        pin_flag_en_r;
   logic [31:0] rdata_r;
   logic        ack_r;

   logic        req;
   logic        wr_lane0;
   logic        reset_wake;
   logic        pd_irq_wake;
   logic        idle_irq_wake;
   logic [2:0]  irq_stall;

   // a request is live until acked; ack drops the cycle after
   assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
   assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

   // reset wake: external always, watchdog only while enabled
   assign reset_wake    = wake_i.ext_reset | (wake_i.wdt_reset & wake_i.wdt_en); // [R7] [R12]
   // power-down ignores timer and comparator events
   assign pd_irq_wake   = wake_i.level_irq | wake_i.pin_irq; // [R12]
   // idle takes every enabled interrupt
   assign idle_irq_wake = wake_i.level_irq | wake_i.pin_irq | wake_i.other_irq; // [R8]
   // halt length after an irq wake depends on the variant
   // a zero count means no stall state at all
   assign irq_stall     = VARIANT_B ? SLC_IRQ_HALT_CYC : SLC_IDLE_WAKE_CYC; // [R10] [R14]

   // one decode of core clock stopped by sleep, shared by halt and checks
   function automatic logic asleep(input slc_state_t s);
      return (s == SLC_IDLE) || (s == SLC_PDOWN);
   endfunction

   // wishbone slave, single cycle answer
   // no wait states: the answer is fixed at one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req;
      end
   end

   // register writes; only the documented bits are writable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r <= SLC_CTRL_RST; // [R15]
         cmp_r  <= SLC_CMP_RST;
      end else if (wr_lane0) begin
         if (wb_adr_i == SLC_CTRL_OFS) begin
            ctrl_r[SLC_ARM_BIT]   <= wb_dat_i[SLC_ARM_BIT]; // [R15]
            ctrl_r[SLC_DEPTH_BIT] <= wb_dat_i[SLC_DEPTH_BIT]; // [R15]
         end
         // cmp bits 6:0 have no storage behind them and stay at reset value
         if (wb_adr_i == SLC_CMP_OFS) begin
            cmp_r[SLC_CMP_OFF_BIT] <= wb_dat_i[SLC_CMP_OFF_BIT]; // [R9]
         end
      end
   end

   // read mux; unmapped addresses read zero and still ack
   // status reads are a snapshot; the stall count may move right after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (req & ~wb_we_i) begin
         unique case (wb_adr_i)
            SLC_CTRL_OFS:   rdata_r <= {24'h00_0000, ctrl_r};
            SLC_STATUS_OFS: rdata_r <= {27'h000_0000, stall_r, state_r};
            SLC_CMP_OFS:    rdata_r <= {24'h00_0000, cmp_r};
            default:        rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // limitation: a wake input that drops before this edge is simply missed;
   // the outside holds wake levels past the reset delay
   // sleep sequencer; it only gates clocks and never writes core state
   always_ff @(posedge clk_i) begin // [R6]
      if (rst_i) begin
         state_r     <= SLC_RUN;
         stall_r     <= 3'h0;
         stall_pin_r <= 1'b0;
      end else begin
         unique case (state_r)
            SLC_RUN: begin
               // unarmed opcode falls through as a no-op
               if (sleep_op_i && ctrl_r[SLC_ARM_BIT]) begin // [R1] [R17]
                  state_r <= ctrl_r[SLC_DEPTH_BIT] ? SLC_PDOWN : SLC_IDLE; // [R2] [R3]
               end
            end
            SLC_IDLE: begin
               if (reset_wake) begin
                  state_r <= SLC_RUN; // [R7]
               end else if (idle_irq_wake) begin // [R4] [R8]
                  if (irq_stall == 3'h0) begin
                     state_r <= SLC_RUN; // [R10]
                  end else begin
                     state_r <= SLC_STALL;
                     stall_r <= irq_stall; // [R14]
                     stall_pin_r <= 1'b0;
                  end
               end
            end
            SLC_PDOWN: begin
               if (reset_wake) begin
                  state_r <= SLC_RUN; // [R7] [R12]
               end else if (pd_irq_wake) begin // [R4] [R12]
                  state_r <= SLC_STALL;
                  if (VARIANT_B) begin
                     stall_r <= SLC_IRQ_HALT_CYC; // [R14]
                     stall_pin_r <= 1'b0;
                  end else begin
                     stall_r <= wake_i.pin_irq ? SLC_PIN_WAKE_CYC : 3'h1; // [R5]
                     stall_pin_r <= wake_i.pin_irq;
                  end
               end
            end
            SLC_STALL: begin
               if (reset_wake) begin
                  state_r <= SLC_RUN; // [R7]
                  stall_r <= 3'h0;
               end else if (stall_r <= 3'h1) begin
                  state_r <= SLC_RUN;
                  stall_r <= 3'h0;
               end else begin
                  stall_r <= stall_r - 3'h1;
               end
            end
         endcase
      end
   end

   // outputs lag the state by one edge so every pin comes from a flop;
   // the price is one extra cycle of halt after a wake
   // registered outputs derived from the current state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_halt_r    <= 1'b0;
         osc_stop_r    <= 1'b0;
         sys_reset_r   <= 1'b0;
         irq_go_r      <= 1'b0;
         pin_flag_en_r <= 1'b1;
      end else begin
         // cpu stopped while asleep; variant b also stalls after wake
         cpu_halt_r  <= asleep(state_r)
                        || (state_r == SLC_STALL && VARIANT_B); // [R2] [R14]
         osc_stop_r  <= (state_r == SLC_PDOWN) && !reset_wake && !pd_irq_wake; // [R11]
         sys_reset_r <= (state_r != SLC_RUN) && reset_wake; // [R7]
         // variant a pin wake: core runs, flag held off both cycles, vector only the second
         pin_flag_en_r <= !(state_r == SLC_STALL && stall_pin_r); // [R5]
         irq_go_r    <= (state_r == SLC_RUN) || (state_r == SLC_STALL && stall_r <= 3'h1
                        && !stall_pin_r && !VARIANT_B) ? 1'b1
                        : (state_r == SLC_STALL && stall_r <= 3'h1); // [R4]
      end
   end

   assign wb_dat_o      = rdata_r;
   assign wb_ack_o      = ack_r;
   assign cpu_halt_o    = cpu_halt_r;
   assign osc_stop_o    = osc_stop_r;
   assign sys_reset_o   = sys_reset_r;
   assign irq_go_o      = irq_go_r;
   assign pin_flag_en_o = pin_flag_en_r;
   assign cmp_off_o     = cmp_r[SLC_CMP_OFF_BIT];

   // assertions: bus handshake and register bits
   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   chk_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("request not answered in one cycle");

   chk_ctrl_reserved: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
      (ctrl_r & 8'hcf) == 8'h00)
      else $error("reserved control bit set");

   // assertions: entering sleep
   chk_unarmed_noop: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
      (state_r == SLC_RUN && sleep_op_i && !ctrl_r[SLC_ARM_BIT]) |=> state_r == SLC_RUN)
      else $error("unarmed sleep opcode changed state");

   chk_run_awake: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
      state_r == SLC_RUN |=> !cpu_halt_o)
      else $error("cpu halted while running");

   chk_idle_entry: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
      (state_r == SLC_RUN && sleep_op_i && ctrl_r[SLC_ARM_BIT] && !ctrl_r[SLC_DEPTH_BIT])
      |=> state_r == SLC_IDLE ##1 cpu_halt_o)
      else $error("idle not entered");

   chk_halt_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
      state_r == SLC_IDLE |=> cpu_halt_o)
      else $error("cpu running in idle");

   chk_idle_osc: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
      state_r == SLC_IDLE |=> !osc_stop_o)
      else $error("oscillator stopped in idle");

   chk_pdown_entry: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      (state_r == SLC_RUN && sleep_op_i && ctrl_r[SLC_ARM_BIT] && ctrl_r[SLC_DEPTH_BIT])
      |=> state_r == SLC_PDOWN)
      else $error("power-down not entered");

   chk_halt_pdown: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
      state_r == SLC_PDOWN |=> cpu_halt_o)
      else $error("cpu running in power-down");

   // assertions: power-down oscillator and wake filter
   chk_osc_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
      osc_stop_o |-> $past(state_r) == SLC_PDOWN)
      else $error("oscillator stopped outside power-down");

   chk_osc_held: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
      (state_r == SLC_PDOWN && !reset_wake && !pd_irq_wake) |=> osc_stop_o)
      else $error("oscillator running in power-down");

   chk_osc_release: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
      (state_r == SLC_PDOWN && (reset_wake || pd_irq_wake)) |=> !osc_stop_o)
      else $error("oscillator not restarted on wake");

   chk_pd_ignore: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
      (state_r == SLC_PDOWN && !reset_wake && !pd_irq_wake) |=> state_r == SLC_PDOWN)
      else $error("power-down left on ignored event");

   // assertions: reset and interrupt wake
   chk_reset_wake: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      (state_r != SLC_RUN && reset_wake) |=> sys_reset_o && state_r == SLC_RUN)
      else $error("reset during sleep not taken");

   chk_reset_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      sys_reset_o |=> !sys_reset_o)
      else $error("reset pulse longer than one cycle");

   chk_run_noreset: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
      state_r == SLC_RUN |=> !sys_reset_o)
      else $error("reset pulse while running");

   chk_irq_go_run: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      state_r == SLC_RUN |=> irq_go_o)
      else $error("irq held off while running");

   chk_irq_held: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
      asleep(state_r) |=> !irq_go_o)
      else $error("irq let through while asleep");

   chk_idle_wake: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
      (state_r == SLC_IDLE && idle_irq_wake && !reset_wake) |=> state_r != SLC_IDLE)
      else $error("idle not left on irq");

   // assertions: post-wake stall per variant
   chk_idle_fast: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
      (!VARIANT_B && state_r == SLC_IDLE && idle_irq_wake && !reset_wake)
      |=> state_r == SLC_RUN)
      else $error("idle wake stalled");

   chk_a_no_halt: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
      (!VARIANT_B && state_r == SLC_STALL) |=> !cpu_halt_o)
      else $error("variant a cpu halted after wake");

   chk_halt_four: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
      (VARIANT_B && state_r == SLC_IDLE && idle_irq_wake && !reset_wake)
      |=> (state_r == SLC_STALL && !reset_wake)[*4] ##1 state_r == SLC_RUN)
      else $error("variant b halt not four cycles");

   chk_b_halt: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
      (VARIANT_B && state_r == SLC_STALL) |=> cpu_halt_o)
      else $error("variant b cpu ran during stall");

   chk_stall_range: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
      state_r == SLC_STALL |-> (stall_r != 3'h0 && stall_r <= SLC_IRQ_HALT_CYC))
      else $error("stall count out of range");

   chk_pin_two: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
      (!VARIANT_B && state_r == SLC_PDOWN && wake_i.pin_irq && !reset_wake)
      |=> ##1 !pin_flag_en_o ##1 !pin_flag_en_o && !cpu_halt_o)
      else $error("pin wake cycles wrong");

   chk_pin_flag_run: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
      state_r != SLC_STALL |=> pin_flag_en_o)
      else $error("pin flag held off outside stall");

endmodule // slc_sleep_ctrl
`default_nettype wire
